// ### core/bmps_pkg.sv
// Package for the boot mode probe sequencer: constants, enums, carriers.
// Assumes a single system clock domain and synchronous active-high reset.
`default_nettype none
package bmps_pkg;

  localparam logic [23:0] BMPS_RESET_VECTOR   = 24'hffff00;
  localparam int          BMPS_CLK_HZ         = 20_000_000;
  localparam int          BMPS_BOOT_DELAY_MS  = 200;
  localparam int          BMPS_BOOT_DELAY_CYC =
    (BMPS_CLK_HZ / 1000) * BMPS_BOOT_DELAY_MS;
  localparam int          BMPS_SPI_HZ         = 500_000;
  localparam int          BMPS_I2C_HZ         = 400_000;
  localparam logic [6:0]  BMPS_I2C_TARGET     = 7'h50;
  localparam logic [9:0]  BMPS_PLL_FB_12M     = 10'h2ed;
  localparam logic [1:0]  BMPS_PLL_LOW_12M    = 2'h0;
  localparam logic [1:0]  BMPS_PLL_OUTDIV_12M = 2'h0;
  localparam logic [10:0] BMPS_PLL_MULT_12M   = 11'h177;
  localparam logic [10:0] BMPS_PLL_MULT_36M_0 = 11'h465;
  localparam logic [10:0] BMPS_PLL_MULT_36M_1 = 11'h003;
  localparam logic [2:0]  BMPS_PPMODE_A       = 3'h5;
  localparam logic [2:0]  BMPS_PPMODE_B       = 3'h6;
  localparam logic [1:0]  BMPS_NUM_CS         = 2'h3;
  localparam logic [4:0]  BMPS_TEMP_RAM_BLOCK = 5'h1f;
  localparam logic [15:0] BMPS_GATE_ALL_OFF   = 16'hffff;

  // Probe source codes driven on probe.src
  typedef enum logic [2:0] {
    BMPS_SRC_NONE, BMPS_SRC_NOR, BMPS_SRC_NAND, BMPS_SRC_SPI16,
    BMPS_SRC_SPI24, BMPS_SRC_I2C, BMPS_SRC_CARD, BMPS_SRC_USB
  } bmps_src_t;

  typedef enum logic [1:0] {
    BMPS_OP_PROBE, BMPS_OP_REGCFG, BMPS_OP_COPY
  } bmps_op_t;

  typedef struct packed {
    logic        power;
    logic        bypass;
    logic [10:0] mult;
    logic [9:0]  fb_field;
    logic [1:0]  low_field;
    logic        in_div_en;
    logic        out_div8_en;
    logic [1:0]  out_div_field;
  } bmps_pll_t;

  typedef struct packed {
    logic        req;
    bmps_op_t    op;
    bmps_src_t   src;
    logic [1:0]  cs_index;
    logic        bus16;
    logic        addr24;
    logic [2:0]  ppmode;
  } bmps_probe_t;

endpackage : bmps_pkg
`default_nettype wire

// ### core/bmps_seq.sv
// Boot mode probe sequencer: reset-to-handoff control flow of the loader.
// Assumes memory-access engines answer probe_req with done and sig_ok.
//
// Behaviour
// R1 - Reset vector fetched from ROM, PLL bypassed
// R2 - All peripheral clocks gated off at reset
// R3 - Slow clock pin, idle all, trim, disable
// R4 - Select 0 programs PLL 12.288 MHz
// R5 - NOR probe chip-selects two..five, 16-bit
// R6 - NAND probe same spaces, 8-bit
// R7 - SPI 500 kHz, 16 then 24-bit address
// R8 - SPI tried with port modes 5, 6
// R9 - I2C EEPROM target 0x50, 400 kHz
// R10 - PLL about 36 MHz before USB
// R11 - Fixed probe order, first valid wins
// R12 - No image: poll USB until reset
// R13 - Apply register configuration, then copy sections
// R14 - Wait 200 ms before running code
// R15 - Finally jump to image entry point
// R16 - Image configuration keeps clock frequency
// R17 - Image configuration leaves delay timer alone
// R18 - Clock only probed peripheral; idle at handoff
// R19 - Temporary data in RAM block 31
// R20 - Software starts USB oscillator, waits
// R21 - Gating and reset via control registers
// R22 - Delay count from post-PLL clock rate; the code derives it from the fixed BMPS_CLK_HZ of 20 MHz instead
`default_nettype none
module bmps_seq
  import bmps_pkg::*;
#(
  parameter int BOOT_DELAY_CYC = BMPS_BOOT_DELAY_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clk_source_sel,
  input  wire logic        step_done,
  input  wire logic        probe_done,
  input  wire logic        sig_ok,
  input  wire logic        cfg_present,
  input  wire logic [23:0] image_entry,
  output logic [23:0]      fetch_addr,
  output logic             rom_map_select,
  output logic             clock_output_pin_slow,
  output logic             clock_output_pin_en,
  output logic             bandgap_trim,
  output logic [15:0]      idle_configuration,
  output logic             memory_port_idle,
  output logic             hardware_accelerator_idle,
  output logic [15:0]      periph_clock_gate_ctl_a,
  output logic [15:0]      periph_clock_gate_ctl_b,
  output logic [15:0]      periph_reset_control,
  output logic [7:0]       periph_reset_counter,
  output bmps_pll_t        pll,
  output bmps_probe_t      probe,
  output logic [31:0]      spi_div,
  output logic [31:0]      i2c_div,
  output logic [6:0]       i2c_target,
  output logic [4:0]       temp_ram_block,
  output logic             temp_ram_reserved,
  output logic             boot_delay_timer_run,
  output logic             jump,
  output logic [23:0]      jump_addr,
  output logic             boot_done
);

  typedef enum logic [4:0] {
    ST_FETCH, ST_SLEW, ST_IDLE, ST_PLL, ST_TRIM, ST_CLKOFF,
    ST_NOR, ST_NAND, ST_SPI, ST_I2C, ST_CARD, ST_PLL36, ST_USB,
    ST_REGCFG, ST_COPY, ST_DELAY, ST_JUMP, ST_DONE
  } bmps_state_t;

  bmps_state_t state_q;
  bmps_state_t state_d;
  logic [1:0]  cs_q;
  logic        addr24_q;
  logic        ppm_q;
  bmps_src_t   found_q;
  bmps_src_t   src_cur;
  bmps_src_t   src_nx;
  bmps_src_t   found_nx;
  bmps_src_t   op_src;
  logic        cs_adv;
  logic        spi_adv;
  logic        addr24_nx;
  logic        ppm_nx;
  logic [31:0] delay_q;
  logic        delay_ok;

  // Gate bit of each probed source within gate register a
  function automatic logic [15:0] gate_mask(input bmps_src_t s);
    logic [15:0] m;
    m = BMPS_GATE_ALL_OFF;
    if (s != BMPS_SRC_NONE) begin
      m[s] = 1'b0;
    end
    return m;
  endfunction

  function automatic logic is_probe(input bmps_state_t s);
    return s == ST_NOR || s == ST_NAND || s == ST_SPI || s == ST_I2C ||
           s == ST_CARD || s == ST_USB;
  endfunction

  assign delay_ok = (delay_q >= BOOT_DELAY_CYC[31:0]);

  // Next state of the boot flow
  always_comb begin
    state_d = state_q;
    case (state_q)
      // R1 reset vector
      ST_FETCH:  state_d = ST_SLEW;
      ST_SLEW:   if (step_done) state_d = ST_IDLE;
      ST_IDLE:   if (step_done) state_d = ST_PLL;
      ST_PLL:    if (step_done) state_d = ST_TRIM;
      ST_TRIM:   if (step_done) state_d = ST_CLKOFF;
      ST_CLKOFF: if (step_done) state_d = ST_NOR;
      // R11 probe order
      ST_NOR: begin
        if (probe_done) begin
          if (sig_ok) begin
            state_d = ST_REGCFG;
          end else if (cs_q == BMPS_NUM_CS) begin
            state_d = ST_NAND;
          end
        end
      end
      ST_NAND: begin
        if (probe_done) begin
          if (sig_ok) begin
            state_d = ST_REGCFG;
          end else if (cs_q == BMPS_NUM_CS) begin
            state_d = ST_SPI;
          end
        end
      end
      ST_SPI: begin
        if (probe_done) begin
          if (sig_ok) begin
            state_d = ST_REGCFG;
          end else if (addr24_q && ppm_q) begin
            state_d = ST_I2C;
          end
        end
      end
      ST_I2C: begin
        if (probe_done) begin
          state_d = sig_ok ? ST_REGCFG : ST_CARD;
        end
      end
      ST_CARD: begin
        if (probe_done) begin
          state_d = sig_ok ? ST_REGCFG : ST_PLL36;
        end
      end
      ST_PLL36: if (step_done) state_d = ST_USB;
      // R12 endless USB poll
      ST_USB: begin
        if (probe_done && sig_ok) begin
          state_d = ST_REGCFG;
        end
      end
      // R13 config then copy
      ST_REGCFG: begin
        if (!cfg_present || probe_done) begin
          state_d = ST_COPY;
        end
      end
      ST_COPY:   if (probe_done) state_d = ST_DELAY;
      // R14 settling wait
      ST_DELAY:  if (delay_ok) state_d = ST_JUMP;
      ST_JUMP:   state_d = ST_DONE;
      ST_DONE:   state_d = ST_DONE;
      default:   state_d = ST_FETCH;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ST_FETCH;
    end else begin
      state_q <= state_d;
    end
  end

  // R5 chip-select sweep
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cs_q <= 2'h0;
    end else if (cs_adv) begin
      cs_q <= cs_q + 2'h1;
    end
  end

  // R7 address width, R8 then port mode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addr24_q <= 1'b0;
      ppm_q    <= 1'b0;
    end else begin
      addr24_q <= addr24_nx;
      ppm_q    <= ppm_nx;
    end
  end

  // Source addressed in a state; SPI width from the address flag
  function automatic bmps_src_t src_of(input bmps_state_t s,
                                       input logic a24);
    case (s)
      ST_NOR:  return BMPS_SRC_NOR;
      ST_NAND: return BMPS_SRC_NAND;
      ST_SPI:  return a24 ? BMPS_SRC_SPI24 : BMPS_SRC_SPI16;
      ST_I2C:  return BMPS_SRC_I2C;
      ST_CARD: return BMPS_SRC_CARD;
      ST_USB:  return BMPS_SRC_USB;
      default: return BMPS_SRC_NONE;
    endcase
  endfunction

  // Next-cycle probe fields, so a request never changes while it stands
  assign cs_adv    = (state_q == ST_NOR || state_q == ST_NAND) &&
                     probe_done && !sig_ok;
  assign spi_adv   = (state_q == ST_SPI) && probe_done && !sig_ok;
  assign addr24_nx = spi_adv ? ~addr24_q : addr24_q;
  assign ppm_nx    = ppm_q || (spi_adv && addr24_q);
  assign src_cur   = src_of(state_q, addr24_q);
  assign src_nx    = src_of(state_d, addr24_nx);
  assign found_nx  = (is_probe(state_q) && probe_done && sig_ok) ?
                     src_cur : found_q;
  assign op_src    = (state_d == ST_REGCFG || state_d == ST_COPY) ?
                     found_nx : src_nx;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      found_q <= BMPS_SRC_NONE;
    end else begin
      found_q <= found_nx;
    end
  end

  // Probe request carrier to the access engines
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      probe <= '0;
    end else begin
      probe.req      <= is_probe(state_d) ||
                        (state_d == ST_REGCFG && cfg_present) ||
                        state_d == ST_COPY;
      probe.op       <= (state_d == ST_REGCFG) ? BMPS_OP_REGCFG :
                        (state_d == ST_COPY) ? BMPS_OP_COPY : BMPS_OP_PROBE;
      probe.src      <= op_src;
      probe.cs_index <= cs_adv ? cs_q + 2'h1 : cs_q;
      // R5 16-bit, R6 8-bit
      probe.bus16    <= (state_d != ST_NAND);
      probe.addr24   <= addr24_nx;
      // R8 port mode
      probe.ppmode   <= ppm_nx ? BMPS_PPMODE_B : BMPS_PPMODE_A;
    end
  end

  // R7 R9 fixed bus rates, target address
  assign spi_div    = BMPS_CLK_HZ / (2 * BMPS_SPI_HZ);
  assign i2c_div    = BMPS_CLK_HZ / (2 * BMPS_I2C_HZ);
  assign i2c_target = BMPS_I2C_TARGET;

  // R1 R2 R3 R18 R21 reset-time power and clock state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fetch_addr                <= BMPS_RESET_VECTOR;
      rom_map_select            <= 1'b0;
      clock_output_pin_slow     <= 1'b0;
      clock_output_pin_en       <= 1'b1;
      bandgap_trim              <= 1'b0;
      idle_configuration        <= 16'h0000;
      memory_port_idle          <= 1'b0;
      hardware_accelerator_idle <= 1'b0;
      periph_clock_gate_ctl_a   <= BMPS_GATE_ALL_OFF;
      periph_clock_gate_ctl_b   <= BMPS_GATE_ALL_OFF;
      periph_reset_control      <= 16'h0000;
      periph_reset_counter      <= 8'h00;
    end else begin
      if (state_q == ST_SLEW) clock_output_pin_slow <= 1'b1;
      if (state_q == ST_IDLE) begin
        idle_configuration        <= 16'hfffe;
        memory_port_idle          <= 1'b1;
        hardware_accelerator_idle <= 1'b1;
      end
      if (state_q == ST_TRIM) bandgap_trim <= 1'b1;
      if (state_q == ST_CLKOFF) clock_output_pin_en <= 1'b0;
      // R18 clock only the probed source
      periph_clock_gate_ctl_a <= gate_mask(op_src);
      // R21 pulse reset each time a probe state is left, hit or miss
      if (is_probe(state_q) && state_d != state_q) begin
        periph_reset_control <= 16'hffff;
        periph_reset_counter <= 8'h08;
      end else begin
        periph_reset_control <= 16'h0000;
        periph_reset_counter <= 8'h00;
      end
    end
  end

  // R4 R10 clock generator programming; R16 relies on image
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pll <= '0;
      pll.bypass <= 1'b1;
    end else if (state_q == ST_PLL && !clk_source_sel) begin
      pll.power         <= 1'b1;
      pll.bypass        <= 1'b0;
      pll.mult          <= BMPS_PLL_MULT_12M;
      pll.fb_field      <= BMPS_PLL_FB_12M;
      pll.low_field     <= BMPS_PLL_LOW_12M;
      pll.in_div_en     <= 1'b0;
      pll.out_div8_en   <= 1'b1;
      pll.out_div_field <= BMPS_PLL_OUTDIV_12M;
    end else if (state_q == ST_PLL36) begin
      pll.power  <= 1'b1;
      pll.bypass <= 1'b0;
      pll.mult   <= clk_source_sel ? BMPS_PLL_MULT_36M_1 :
                                     BMPS_PLL_MULT_36M_0;
    end
  end

  // R14 R22 delay counter on clk_sys; R17 timer private
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      delay_q <= 32'h0;
    end else if (state_q == ST_DELAY && !delay_ok) begin
      delay_q <= delay_q + 32'h1;
    end
  end
  assign boot_delay_timer_run = (state_q == ST_DELAY);

  // R19 scratch block reserved until boot completes
  assign temp_ram_block    = BMPS_TEMP_RAM_BLOCK;
  assign temp_ram_reserved = (state_q != ST_DONE);

  // R15 handoff to entry point
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      jump      <= 1'b0;
      jump_addr <= 24'h0;
      boot_done <= 1'b0;
    end else begin
      jump <= (state_q == ST_JUMP);
      if (state_q == ST_JUMP) begin
        jump_addr <= image_entry;
        boot_done <= 1'b1;
      end
    end
  end

endmodule : bmps_seq
`default_nettype wire

// ### sim/bmps_seq_chk.sv
// Checker for the boot sequencer: probe, clock and handoff relations.
// Assumes it is bound onto bmps_seq and sees only its ports.
`default_nettype none
module bmps_seq_chk
  import bmps_pkg::*;
#(
  parameter int BOOT_DELAY_CYC = BMPS_BOOT_DELAY_CYC
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        clk_source_sel,
  input wire logic        probe_done,
  input wire logic        sig_ok,
  input wire logic        cfg_present,
  input wire logic [23:0] image_entry,
  input wire logic [23:0] fetch_addr,
  input wire logic        clock_output_pin_en,
  input wire logic [15:0] idle_configuration,
  input wire logic [15:0] periph_clock_gate_ctl_a,
  input wire bmps_pll_t   pll,
  input wire bmps_probe_t probe,
  input wire logic [6:0]  i2c_target,
  input wire logic        boot_delay_timer_run,
  input wire logic        jump,
  input wire logic [23:0] jump_addr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [31:0] dly_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dly_q <= 32'h0;
    end else if (boot_delay_timer_run) begin
      dly_q <= dly_q + 32'h1;
    end
  end
  AST_RST_VAL: assert property (
    $fell(rst) |-> fetch_addr == BMPS_RESET_VECTOR && pll.bypass
      && periph_clock_gate_ctl_a == BMPS_GATE_ALL_OFF)
    else $error("reset state wrong");
  AST_EARLY: assert property (
    probe.req |-> !clock_output_pin_en)
    else $error("clock pin still on while probing");
  AST_PLL12: assert property (
    probe.req && probe.src == BMPS_SRC_NOR |-> (clk_source_sel ? pll.bypass
      : (pll.power && !pll.bypass && pll.mult == BMPS_PLL_MULT_12M
      && pll.fb_field == BMPS_PLL_FB_12M && pll.out_div8_en)))
    else $error("pll setting wrong");
  AST_PLL36: assert property (
    probe.req && probe.src == BMPS_SRC_USB |-> pll.mult ==
      (clk_source_sel ? BMPS_PLL_MULT_36M_1 : BMPS_PLL_MULT_36M_0))
    else $error("pll not near 36 MHz");
  AST_GATE: assert property (
    probe.req |-> periph_clock_gate_ctl_a == ~(16'h0001 << probe.src))
    else $error("wrong clock ungated");
  AST_I2C: assert property (
    probe.req && probe.src == BMPS_SRC_I2C |-> i2c_target == BMPS_I2C_TARGET)
    else $error("i2c target wrong");
  AST_CFG: assert property (
    probe.req && probe_done && sig_ok && probe.op == BMPS_OP_PROBE |=>
      probe.op == BMPS_OP_REGCFG && probe.req == cfg_present)
    else $error("load step order wrong");
  AST_DELAY: assert property (
    jump |-> dly_q >= BOOT_DELAY_CYC && !boot_delay_timer_run)
    else $error("jump before delay");
  AST_HAND: assert property (
    jump |-> periph_clock_gate_ctl_a == BMPS_GATE_ALL_OFF
      && idle_configuration == 16'hfffe)
    else $error("handoff state wrong");
  AST_ENTRY: assert property (
    jump |-> jump_addr == image_entry)
    else $error("jump address wrong");
  cover property (jump);
  cover property (probe.req && probe.src == BMPS_SRC_USB);
  cover property (probe.req && probe.op == BMPS_OP_REGCFG);
endmodule // bmps_seq_chk
bind bmps_seq bmps_seq_chk #(.BOOT_DELAY_CYC(BOOT_DELAY_CYC)) u_bmps_seq_chk (
  .clk_sys, .rst, .clk_source_sel, .probe_done, .sig_ok, .cfg_present,
  .image_entry, .fetch_addr, .clock_output_pin_en, .idle_configuration,
  .periph_clock_gate_ctl_a, .pll, .probe, .i2c_target,
  .boot_delay_timer_run, .jump, .jump_addr);
`default_nettype wire

// ### sim/bmps_mem.sv
// Boot memory model: answers each probe, config and copy request.
// Assumes probe.req stands until probe_done; one hit attempt per boot.
`default_nettype none
module bmps_mem
  import bmps_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire bmps_probe_t probe,
  input  wire logic [4:0]  hit,
  input  wire logic [3:0]  lat,
  output logic             probe_done,
  output logic             sig_ok
);
  logic [3:0] cnt_q;
  logic [4:0] att_q;
  // answer latency stands in for USB oscillator start
  always_ff @(posedge clk_sys) begin
    if (rst || !probe.req || probe_done) cnt_q <= 4'h0;
    else cnt_q <= cnt_q + 4'h1;
  end
  always_ff @(posedge clk_sys) begin
    probe_done <= !rst && probe.req && !probe_done && cnt_q == lat;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) att_q <= 5'h0;
    else if (probe_done && probe.op == BMPS_OP_PROBE && att_q != 5'h1f)
      att_q <= att_q + 5'h1;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) sig_ok <= 1'b0;
    else if (probe.req && !probe_done && cnt_q == lat)
      sig_ok <= probe.op != BMPS_OP_PROBE || (att_q == hit && hit != 5'h1f);
    else sig_ok <= ~sig_ok;
  end
endmodule // bmps_mem
`default_nettype wire

// ### sim/bmps_seq_tb_top.sv
// Bench for the boot sequencer: boots from several sources in turn.
// Assumes the memory model answers probes; delay shortened to 20.
`default_nettype none
module bmps_seq_tb_top
  import bmps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DLY = 20;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        clk_source_sel = 1'b0;
  logic        step_done = 1'b0;
  logic        cfg_present = 1'b0;
  logic [23:0] image_entry = 24'h0;
  logic [4:0]  hit = 5'h1f;
  logic [3:0]  lat = 4'h0;
  logic        probe_done, sig_ok, jump, boot_done, saw_cfg, run;
  logic        ram_rsv, clk_en, rom_sel, clk_slow, bg_trim, mp_idle;
  logic        hwa_idle, rst_chk, rst_exp;
  logic [2:0]  pm_exp;
  logic [4:0]  ram_blk;
  logic [6:0]  i2c_tgt;
  logic [7:0]  rst_cnt;
  logic [23:0] fetch_addr, jump_addr;
  logic [15:0] gate_a, idle_cfg, gate_b, rst_ctl;
  logic [31:0] spi_div, i2c_div;
  bmps_pll_t   pll;
  bmps_probe_t probe;
  int          bad_count = 0, n_compared = 0, cyc = 0, att = 0, run_n = 0;
  bmps_seq #(.BOOT_DELAY_CYC(DLY)) u_bmps_seq (
    .clk_sys, .rst, .clk_source_sel, .step_done, .probe_done, .sig_ok,
    .cfg_present, .image_entry, .fetch_addr, .rom_map_select(rom_sel),
    .clock_output_pin_slow(clk_slow), .clock_output_pin_en(clk_en),
    .bandgap_trim(bg_trim), .idle_configuration(idle_cfg),
    .memory_port_idle(mp_idle), .hardware_accelerator_idle(hwa_idle),
    .periph_clock_gate_ctl_a(gate_a), .periph_clock_gate_ctl_b(gate_b),
    .periph_reset_control(rst_ctl), .periph_reset_counter(rst_cnt),
    .pll, .probe, .spi_div, .i2c_div, .i2c_target(i2c_tgt),
    .temp_ram_block(ram_blk), .temp_ram_reserved(ram_rsv),
    .boot_delay_timer_run(run), .jump, .jump_addr, .boot_done);
  bmps_mem u_bmps_mem (.clk_sys, .rst, .probe, .hit, .lat, .probe_done,
    .sig_ok);
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic bmps_src_t ex_src(input int i);
    if (i < 4) return BMPS_SRC_NOR;
    if (i < 8) return BMPS_SRC_NAND;
    if (i < 12) return i[0] ? BMPS_SRC_SPI24 : BMPS_SRC_SPI16;
    if (i == 12) return BMPS_SRC_I2C;
    if (i == 13) return BMPS_SRC_CARD;
    return BMPS_SRC_USB;
  endfunction
  task automatic boot(input logic s, c, input logic [4:0] h,
                      input logic [3:0] l, input logic [23:0] e);
    @(posedge clk_sys);
    #5;
    rst = 1'b1;
    step_done = 1'b0;
    clk_source_sel = s;
    cfg_present = c;
    hit = h;
    lat = l;
    image_entry = e;
    repeat (8) @(posedge clk_sys);
    #5 rst = 1'b0;
    @(negedge clk_sys);
    cmp(fetch_addr, BMPS_RESET_VECTOR);
    cmp(gate_a, BMPS_GATE_ALL_OFF);
    cmp(pll.bypass, 1'b1);
    repeat (2) @(posedge clk_sys);
    #5 step_done = 1'b1;
  endtask
  task automatic wait_jump();
    int k;
    for (k = 0; k < 400 && jump !== 1'b1; k++) @(negedge clk_sys);
    cmp(jump, 1'b1);
    cmp(jump_addr, image_entry);
    cmp(run_n >= DLY, 1'b1);
    cmp(gate_a, BMPS_GATE_ALL_OFF);
    cmp(idle_cfg, 16'hfffe);
    cmp({rom_sel, clk_slow, bg_trim, mp_idle, hwa_idle}, 5'h0f);
    cmp(gate_b, BMPS_GATE_ALL_OFF);
    cmp(ram_blk, BMPS_TEMP_RAM_BLOCK);
  endtask
  // Probe order and probe settings at each answer
  always @(negedge clk_sys) begin
    if (rst) begin
      att = 0;
      run_n = 0;
      saw_cfg = 1'b0;
      rst_chk = 1'b0;
    end else begin
      if (run) run_n++;
      if (probe.req && probe.op == BMPS_OP_REGCFG) saw_cfg = 1'b1;
      if (rst_chk) begin
        cmp({rst_ctl, rst_cnt}, rst_exp ? 24'hffff08 : 24'h0);
        rst_chk = 1'b0;
      end
      if (probe_done && probe.op == BMPS_OP_PROBE) begin
        cmp(probe.src, ex_src(att));
        rst_chk = 1'b1;
        rst_exp = sig_ok || att == 3 || att == 7 || (att > 10 && att < 14);
        if (att < 8) begin
          cmp({probe.cs_index, probe.bus16}, {att[1:0], att < 4});
        end else if (att < 12) begin
          pm_exp = (att < 10) ? BMPS_PPMODE_A : BMPS_PPMODE_B;
          cmp({probe.ppmode, probe.addr24}, {pm_exp, att[0]});
          cmp(spi_div, BMPS_CLK_HZ / (2 * BMPS_SPI_HZ));
        end else if (att == 12) begin
          cmp(i2c_div, BMPS_CLK_HZ / (2 * BMPS_I2C_HZ));
          cmp(i2c_tgt, BMPS_I2C_TARGET);
        end
        att++;
      end
    end
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      $display("[FAIL] %0t timeout", $time);
      end_sim();
    end
  end
  initial begin
    int k;
    int s;
    boot(1'b0, 1'b1, 5'h09, 4'h0, 24'h012345);
    wait_jump();
    cmp(att, 10);
    cmp(saw_cfg, 1'b1);
    repeat (2) @(negedge clk_sys);
    cmp(boot_done, 1'b1);
    cmp(ram_rsv, 1'b0);
    $display("test 1 done");
    boot(1'b1, 1'b0, 5'h00, 4'h3, 24'h00abcd);
    wait_jump();
    cmp(att, 1);
    cmp(saw_cfg, 1'b0);
    cmp(pll.bypass, 1'b1);
    $display("test 2 done");
    for (s = 0; s < 2; s++) begin
      boot(s[0], 1'b0, 5'h1f, 4'h5, 24'h000000);
      for (k = 0; k < 300 && att < 16; k++) @(negedge clk_sys);
      cmp(att >= 16, 1'b1);
      cmp(boot_done, 1'b0);
      cmp(ram_rsv, 1'b1);
      cmp(pll.mult, s ? BMPS_PLL_MULT_36M_1 : BMPS_PLL_MULT_36M_0);
      cmp(pll.bypass, 1'b0);
      cmp(clk_en, 1'b0);
    end
    $display("test 3 done");
    boot(1'b1, 1'b1, 5'h0c, 4'h2, 24'h5a0f31);
    wait_jump();
    cmp(att, 13);
    cmp(saw_cfg, 1'b1);
    $display("test 4 done");
    end_sim();
  end
endmodule // bmps_seq_tb_top
`default_nettype wire
